// File: pkg/baud_dma_pkg.sv
package baud_dma_pkg;

    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [7:0] addr_divisor_low_byte  = 8'h00;
    localparam logic [7:0] addr_divisor_high_byte = 8'h04;
    localparam logic [7:0] addr_fractional_div    = 8'h08;
    localparam logic [7:0] addr_modem_control     = 8'h0c;
    localparam logic [7:0] addr_fifo_control      = 8'h10;
    localparam logic [7:0] addr_tx_irq_level      = 8'h14;
    localparam logic [7:0] addr_rx_irq_level      = 8'h18;
    localparam logic [7:0] addr_flow_high_mark    = 8'h1c;
    localparam logic [7:0] addr_flow_low_mark     = 8'h20;
    localparam logic [7:0] addr_status            = 8'h24;

    // Field positions.
    localparam int prescale_bit   = 7;
    localparam int fifo_en_bit    = 0;
    localparam int dma_mode_bit   = 3;
    localparam int frac_width     = 4;

    // Reset values.
    localparam logic [7:0] divisor_low_reset  = 8'h01;
    localparam logic [7:0] divisor_high_reset = 8'h00;
    localparam logic [7:0] byte_reg_reset     = 8'h00;

    // Prescale factors and oversampling.
    localparam logic [2:0] prescale_one       = 3'h1;
    localparam logic [2:0] prescale_four      = 3'h4;
    localparam logic [4:0] oversample_ticks   = 5'h10;

    // FIFO depths.
    localparam logic [7:0] depth_normal       = 8'h20;
    localparam logic [7:0] depth_extended     = 8'h80;

    // Receive time-out span, in character times.
    localparam logic [2:0] timeout_chars      = 3'h4;

    // Highest input clock the generator is built for, in MHz.
    localparam int max_input_mhz = 80;

    // AXI responses.
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// File: design/uart_baud_gen_dma_ready.sv
// Behaviour
// RL1: Integer divisor ranges one to 65535.
// RL2: Rate is clock over prescale*16*(N+M/16).
// RL3: Modem control bit 7 selects prescale four.
// RL4: High byte is divisor top, low byte bottom.
// RL5: Fraction M is low four bits.
// RL6: One tick feeds both transmitter and receiver.
// RL7: Generator works up to 80 MHz input.
// RL8: Sixteen ticks make one bit period.
// RL9: FIFO control bit 3 selects DMA signalling.
// RL10: Non-DMA receive ready high only when empty.
// RL11: DMA receive ready rises when FIFO empties.
// RL12: DMA receive ready falls at trigger or time-out.
// RL13: Non-DMA transmit ready high when FIFO holds data.
// RL14: DMA transmit ready rises when FIFO full.
// RL15: DMA transmit ready falls on free location.
// RL16: Receive full at 32, or 128 extended.
// RL17: Transmit full at 32, or 128 extended.
// RL18: Depth change flushes both FIFOs.
// RL19: Time-out after four idle character times.
// RL20: Single-cycle tick with fractional accumulation.
// RL21: Software never programs a zero divisor.
module uart_baud_gen_dma_ready (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  rx_fifo_count,
    input  wire logic [7:0]  tx_fifo_count,
    input  wire logic [7:0]  rx_trigger_level,
    input  wire logic        rx_stop_center,
    input  wire logic        rx_data_read,
    output logic             baud_tick,
    output logic             bit_tick,
    output logic             fifo_flush,
    output logic             rx_timeout,
    output logic             rx_dma_ready,
    output logic             tx_dma_ready
);

    logic [7:0]  divisor_low_r;
    logic [7:0]  divisor_high_r;
    logic [7:0]  fractional_divisor_reg;
    logic [7:0]  modem_control_reg;
    logic [7:0]  fifo_control_reg;
    logic [7:0]  tx_irq_level;
    logic [7:0]  rx_irq_level;
    logic [7:0]  flow_high_mark;
    logic [7:0]  flow_low_mark;

    // Write channel capture: address and data may arrive in either order.
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a[1:0] == 2'h0) && (a <= baud_dma_pkg::addr_status);
    endfunction

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    wire        aw_take   = s_axi_awvalid && s_axi_awready;
    wire        w_take    = s_axi_wvalid && s_axi_wready;
    wire        aw_have   = aw_held_r || aw_take;
    wire        w_have    = w_held_r || w_take;
    wire        wr_fire   = aw_have && w_have;
    wire [7:0]  wr_addr   = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data   = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0]  wr_strb   = w_held_r ? w_strb_r : s_axi_wstrb;
    wire        wr_lane0  = wr_fire && wr_strb[0];
    wire [7:0]  wr_byte   = wr_data[7:0];

    // Each half of a write waits in its holding flag until the other half arrives.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
        end else begin
            aw_held_r <= aw_have && !wr_fire;
            w_held_r  <= w_have && !wr_fire;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= 8'h00;
        end else if (aw_take) begin
            aw_addr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (w_take) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
    end

    // While a response stands both ready outputs stay low, so writes cannot overlap.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= baud_dma_pkg::resp_okay;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= addr_known(wr_addr) ? baud_dma_pkg::resp_okay
                                            : baud_dma_pkg::resp_slverr;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Registers; the status word is read-only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divisor_low_r          <= baud_dma_pkg::divisor_low_reset;
            divisor_high_r         <= baud_dma_pkg::divisor_high_reset;
            fractional_divisor_reg <= baud_dma_pkg::byte_reg_reset;
            modem_control_reg      <= baud_dma_pkg::byte_reg_reset;
            fifo_control_reg       <= baud_dma_pkg::byte_reg_reset;
            tx_irq_level           <= baud_dma_pkg::byte_reg_reset;
            rx_irq_level           <= baud_dma_pkg::byte_reg_reset;
            flow_high_mark         <= baud_dma_pkg::byte_reg_reset;
            flow_low_mark          <= baud_dma_pkg::byte_reg_reset;
        end else if (wr_lane0) begin
            case (wr_addr)
                baud_dma_pkg::addr_divisor_low_byte:  divisor_low_r <= wr_byte; // RL4
                baud_dma_pkg::addr_divisor_high_byte: divisor_high_r <= wr_byte; // RL4
                baud_dma_pkg::addr_fractional_div:    fractional_divisor_reg <= wr_byte;
                baud_dma_pkg::addr_modem_control:     modem_control_reg <= wr_byte;
                baud_dma_pkg::addr_fifo_control:      fifo_control_reg <= wr_byte;
                baud_dma_pkg::addr_tx_irq_level:      tx_irq_level <= wr_byte;
                baud_dma_pkg::addr_rx_irq_level:      rx_irq_level <= wr_byte;
                baud_dma_pkg::addr_flow_high_mark:    flow_high_mark <= wr_byte;
                baud_dma_pkg::addr_flow_low_mark:     flow_low_mark <= wr_byte;
                default: ;
            endcase
        end
    end

    // Fractional baud generator.
    wire [15:0] divisor_n  = {divisor_high_r, divisor_low_r}; // RL4
    wire [3:0]  frac_m     = fractional_divisor_reg[baud_dma_pkg::frac_width-1:0]; // RL5
    wire [2:0]  prescale   = modem_control_reg[baud_dma_pkg::prescale_bit] ?
                             baud_dma_pkg::prescale_four : baud_dma_pkg::prescale_one; // RL3
    // A zero divisor would stall the tick, so it is treated as one.
    wire [15:0] divisor_ok = (divisor_n == 16'h0000) ? 16'h0001 : divisor_n; // RL1 RL21

    // Period in sixteenths of a clock: prescale * (16*N + M); the low nibble is the
    // fraction, carried from tick to tick so the mean period is exact.
    wire [21:0] period_16  = 22'({divisor_ok, frac_m}) * 22'(prescale); // RL2
    logic [21:0] phase_r;
    wire        at_tick    = (phase_r[21:4] == 18'h00001) || (phase_r[21:4] == 18'h00000);
    wire [21:0] phase_nxt  = at_tick ? 22'(period_16 + {18'h0, phase_r[3:0]}) // RL20
                                     : 22'(phase_r - 22'h10);
    logic [3:0] oversample_r;
    logic       tick_r;
    logic       bit_tick_r;

    // Counting runs on the register clock, which is rated to 80 MHz. // RL7
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 22'h000010;
            tick_r  <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            tick_r  <= at_tick; // RL20
        end
    end

    // The bit counter only moves on ticks, so a bit spans sixteen of them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oversample_r <= 4'h0;
            bit_tick_r   <= 1'b0;
        end else begin
            bit_tick_r <= at_tick && (oversample_r == 4'(baud_dma_pkg::oversample_ticks - 5'h1));
            if (at_tick) begin
                oversample_r <= oversample_r + 4'h1; // RL8
            end
        end
    end

    assign baud_tick = tick_r; // RL6
    assign bit_tick  = bit_tick_r; // RL8

    // FIFO depth and flush on any depth change.
    wire fifo_en    = fifo_control_reg[baud_dma_pkg::fifo_en_bit];
    wire extended   = |{tx_irq_level, rx_irq_level, flow_high_mark, flow_low_mark};
    wire [7:0] depth = extended ? baud_dma_pkg::depth_extended
                                : baud_dma_pkg::depth_normal; // RL16 RL17
    logic fifo_en_r;
    logic extended_r;
    logic flush_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_en_r  <= 1'b0;
            extended_r <= 1'b0;
            flush_r    <= 1'b0;
        end else begin
            fifo_en_r  <= fifo_en;
            extended_r <= extended;
            flush_r    <= (fifo_en != fifo_en_r) || (extended != extended_r); // RL18
        end
    end

    assign fifo_flush = flush_r;

    // Receive time-out: four character times counted in bit periods; a character
    // is taken as ten bits, since the frame format lives elsewhere.
    localparam logic [5:0] timeout_bits = 6'(baud_dma_pkg::timeout_chars) * 6'h0a;
    wire  rx_empty = (rx_fifo_count == 8'h00);
    logic [5:0] idle_bits_r;
    logic       timeout_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_bits_r <= 6'h00;
            timeout_r   <= 1'b0;
        end else if (rx_empty || rx_stop_center || rx_data_read || flush_r) begin
            idle_bits_r <= 6'h00;
            timeout_r   <= 1'b0;
        end else if (bit_tick_r && idle_bits_r != timeout_bits) begin
            idle_bits_r <= idle_bits_r + 6'h01;
            timeout_r   <= (idle_bits_r + 6'h01) == timeout_bits; // RL19
        end
    end

    assign rx_timeout = timeout_r;

    // Ready outputs.
    wire dma_mode   = fifo_control_reg[baud_dma_pkg::dma_mode_bit]; // RL9
    wire rx_trigger = (rx_fifo_count >= rx_trigger_level) || (rx_fifo_count >= depth);
    wire tx_full    = (tx_fifo_count >= depth); // RL17
    wire tx_empty   = (tx_fifo_count == 8'h00);
    logic rx_ready_r;
    logic tx_ready_r;

    // An empty receive FIFO wins over a trigger or time-out seen in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ready_r <= 1'b1;
        end else if (!dma_mode) begin
            rx_ready_r <= rx_empty; // RL10
        end else if (rx_empty) begin
            rx_ready_r <= 1'b1; // RL11
        end else if (rx_trigger || timeout_r) begin
            rx_ready_r <= 1'b0; // RL12
        end
    end

    // In DMA mode transmit ready is high only while the FIFO is full.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_ready_r <= 1'b0;
        end else if (!dma_mode) begin
            tx_ready_r <= !tx_empty; // RL13
        end else if (tx_full) begin
            tx_ready_r <= 1'b1; // RL14
        end else begin
            tx_ready_r <= 1'b0; // RL15
        end
    end

    assign rx_dma_ready = rx_ready_r;
    assign tx_dma_ready = tx_ready_r;

    // Read path; status shows live ready, time-out and depth state.
    wire [31:0] status_word = {24'h0, 4'h0, extended, timeout_r, tx_ready_r, rx_ready_r};
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            baud_dma_pkg::addr_divisor_low_byte:  rd_mux = {24'h0, divisor_low_r};
            baud_dma_pkg::addr_divisor_high_byte: rd_mux = {24'h0, divisor_high_r};
            baud_dma_pkg::addr_fractional_div:    rd_mux = {24'h0, fractional_divisor_reg};
            baud_dma_pkg::addr_modem_control:     rd_mux = {24'h0, modem_control_reg};
            baud_dma_pkg::addr_fifo_control:      rd_mux = {24'h0, fifo_control_reg};
            baud_dma_pkg::addr_tx_irq_level:      rd_mux = {24'h0, tx_irq_level};
            baud_dma_pkg::addr_rx_irq_level:      rd_mux = {24'h0, rx_irq_level};
            baud_dma_pkg::addr_flow_high_mark:    rd_mux = {24'h0, flow_high_mark};
            baud_dma_pkg::addr_flow_low_mark:     rd_mux = {24'h0, flow_low_mark};
            baud_dma_pkg::addr_status:            rd_mux = status_word;
            default:                              rd_mux = 32'h0000_0000;
        endcase
    end

    wire ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Data and response are caught with the address, so a later address change is harmless.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= baud_dma_pkg::resp_okay;
        end else if (ar_take) begin
            rdata_r <= rd_mux;
            rresp_r <= addr_known(s_axi_araddr) ? baud_dma_pkg::resp_okay
                                                : baud_dma_pkg::resp_slverr;
        end
    end

endmodule

// File: sim/uart_baud_gen_dma_ready_props.sv
module baud_dma_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  rx_fifo_count,
    input wire logic [7:0]  tx_fifo_count,
    input wire logic [7:0]  rx_trigger_level,
    input wire logic        bit_tick,
    input wire logic        fifo_flush,
    input wire logic        rx_timeout,
    input wire logic        rx_dma_ready,
    input wire logic        tx_dma_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_RX_EMPTY: assert property (rx_fifo_count == 8'h00 |=> rx_dma_ready)
        else $error("receive ready not high after empty");
    AST_RX_TRIG: assert property (rx_fifo_count != 8'h00 &&
        rx_fifo_count >= rx_trigger_level |=> !rx_dma_ready)
        else $error("receive ready not low at trigger");
    AST_RX_TMO: assert property (rx_timeout && rx_fifo_count != 8'h00 |=> !rx_dma_ready)
        else $error("receive ready not low after time-out");
    AST_TMO_EMPTY: assert property (rx_fifo_count == 8'h00 |=> !rx_timeout)
        else $error("time-out with empty receive fifo");
    AST_TX_EMPTY: assert property (tx_fifo_count == 8'h00 |=> !tx_dma_ready)
        else $error("transmit ready high with empty fifo");
    AST_BIT_GAP: assert property (bit_tick |=> !bit_tick [*8])
        else $error("bit ticks too close");
    AST_FLUSH_PULSE: assert property ($rose(fifo_flush) |=> !fifo_flush)
        else $error("flush longer than one cycle");
    AST_WRITE_ANSWER: assert property (w_taken |=> s_axi_bvalid)
        else $error("write response late");
    AST_READ_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read response late");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
endmodule

bind uart_baud_gen_dma_ready baud_dma_checker chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .rx_fifo_count, .tx_fifo_count, .rx_trigger_level, .bit_tick, .fifo_flush,
    .rx_timeout, .rx_dma_ready, .tx_dma_ready
);

// File: sim/fifo_side_model.sv
module fifo_side_model (
    input  wire logic  aclk,
    input  wire logic  fifo_flush,
    output logic [7:0] rx_fifo_count,
    output logic [7:0] tx_fifo_count,
    output logic [7:0] rx_trigger_level,
    output logic       rx_stop_center,
    output logic       rx_data_read
);
    timeunit 1ns;
    timeprecision 1ps;
    int flushes = 0;
    // No line traffic is modelled, so the time-out restart strobes stay idle.
    initial begin
        rx_fifo_count = 8'h00;
        tx_fifo_count = 8'h00;
        rx_trigger_level = 8'h08;
        rx_stop_center = 1'b0;
        rx_data_read = 1'b0;
    end
    always @(posedge aclk) begin
        if (fifo_flush === 1'b1) begin
            flushes <= flushes + 1;
            rx_fifo_count <= 8'h00;
            tx_fifo_count <= 8'h00;
        end
    end
    // Callers keep counts within the depth in force, as real storage would.
    task automatic load(input logic [7:0] rx, input logic [7:0] tx, input logic [7:0] trig);
        @(posedge aclk);
        rx_fifo_count <= rx;
        tx_fifo_count <= tx;
        rx_trigger_level <= trig;
    endtask
endmodule

// File: sim/test_uart_baud_gen_dma_ready.sv
module test_uart_baud_gen_dma_ready;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0]  rx_fifo_count, tx_fifo_count, rx_trigger_level;
    logic        rx_stop_center, rx_data_read, baud_tick, bit_tick;
    logic        fifo_flush, rx_timeout, rx_dma_ready, tx_dma_ready;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          n, f;
    always #12.5 aclk = ~aclk;
    uart_baud_gen_dma_ready dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_fifo_count, .tx_fifo_count,
        .rx_trigger_level, .rx_stop_center, .rx_data_read, .baud_tick, .bit_tick,
        .fifo_flush, .rx_timeout, .rx_dma_ready, .tx_dma_ready
    );
    fifo_side_model fifo_u (
        .aclk, .fifo_flush, .rx_fifo_count, .tx_fifo_count, .rx_trigger_level,
        .rx_stop_center, .rx_data_read
    );
    task print_verdict;
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task hang;
        num_errors++;
        $display("unexpected wait expected done seen timeout");
        print_verdict;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Ready is sampled between edges so the taking edge is known before it comes.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int k;
        logic ta = 1'b0, tw = 1'b0, tb = 1'b0;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; !(ta && tw); k++) begin
            if (k > 50) hang;
            @(negedge aclk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        for (k = 0; !tb; k++) begin
            if (k > 50) hang;
            @(negedge aclk);
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        logic t = 1'b0;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; !t; k++) begin
            if (k > 50) hang;
            @(negedge aclk);
            t = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        t = 1'b0;
        for (k = 0; !t; k++) begin
            if (k > 50) hang;
            @(negedge aclk);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        chk("rdata", ed, d);
        chk("rresp", 32'(er), 32'(r));
    endtask
    task automatic ready_chk(input logic [7:0] rx, tx, trig, input logic er, et);
        fifo_u.load(rx, tx, trig);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("rx_dma_ready", 32'(er), 32'(rx_dma_ready));
        chk("tx_dma_ready", 32'(et), 32'(tx_dma_ready));
    endtask
    // Each setting is watched for 80 tick periods; one tick of jitter is allowed.
    task automatic rate(input logic [7:0] lo, hi, mc, fr, input int w);
        int nb = 0, ns = 0;
        wr(baud_dma_pkg::addr_divisor_low_byte, {24'h0, lo}, 4'hf, baud_dma_pkg::resp_okay);
        wr(baud_dma_pkg::addr_divisor_high_byte, {24'h0, hi}, 4'hf, baud_dma_pkg::resp_okay);
        wr(baud_dma_pkg::addr_modem_control, {24'h0, mc}, 4'hf, baud_dma_pkg::resp_okay);
        wr(baud_dma_pkg::addr_fractional_div, {24'h0, fr}, 4'hf, baud_dma_pkg::resp_okay);
        // A half-written setting may load a countdown of over a thousand cycles.
        repeat (1100) @(posedge aclk);
        for (int i = 0; i < w; i++) begin
            @(negedge aclk);
            nb += int'(baud_tick === 1'b1);
            ns += int'(bit_tick === 1'b1);
        end
        cmp_count += 2;
        if (nb < 79 || nb > 81) begin
            num_errors++;
            $display("unexpected baud_tick count expected %0d seen %0d", 80, nb);
        end
        if (ns < 4 || ns > 6) begin
            num_errors++;
            $display("unexpected bit_tick count expected %0d seen %0d", 5, ns);
        end
    endtask
    initial begin
        #2500000;
        hang;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("rx_dma_ready", 32'h1, 32'(rx_dma_ready));
        chk("tx_dma_ready", 32'h0, 32'(tx_dma_ready));
        rd(baud_dma_pkg::addr_divisor_low_byte, 32'h1, baud_dma_pkg::resp_okay);
        rd(8'h40, 32'h0, baud_dma_pkg::resp_slverr);
        wr(8'h40, 32'h55, 4'hf, baud_dma_pkg::resp_slverr);
        wr(baud_dma_pkg::addr_fractional_div, 32'h3, 4'h0, baud_dma_pkg::resp_okay);
        rd(baud_dma_pkg::addr_fractional_div, 32'h0, baud_dma_pkg::resp_okay);
        rate(8'h05, 8'h00, 8'h00, 8'h0, 400);
        rate(8'h05, 8'h00, 8'h80, 8'h0, 1600);
        rate(8'h02, 8'h00, 8'h00, 8'h8, 200);
        rate(8'h01, 8'h00, 8'h80, 8'h3, 380);
        rate(8'h00, 8'h01, 8'h00, 8'h0, 20480);
        wr(baud_dma_pkg::addr_divisor_low_byte, 32'h1, 4'hf, baud_dma_pkg::resp_okay);
        wr(baud_dma_pkg::addr_divisor_high_byte, 32'h0, 4'hf, baud_dma_pkg::resp_okay);
        repeat (300) @(posedge aclk);
        ready_chk(8'd3, 8'd0, 8'd8, 1'b0, 1'b0);
        ready_chk(8'd0, 8'd5, 8'd8, 1'b1, 1'b1);
        f = fifo_u.flushes;
        wr(baud_dma_pkg::addr_fifo_control, 32'h9, 4'hf, baud_dma_pkg::resp_okay);
        repeat (3) @(posedge aclk);
        chk("flush count", 32'(f + 1), 32'(fifo_u.flushes));
        ready_chk(8'd4, 8'd31, 8'd8, 1'b1, 1'b0);
        ready_chk(8'd8, 8'd32, 8'd8, 1'b0, 1'b1);
        ready_chk(8'd4, 8'd31, 8'd8, 1'b0, 1'b0);
        ready_chk(8'd0, 8'd31, 8'd8, 1'b1, 1'b0);
        wr(baud_dma_pkg::addr_tx_irq_level, 32'h1, 4'hf, baud_dma_pkg::resp_okay);
        repeat (3) @(posedge aclk);
        chk("flush count", 32'(f + 2), 32'(fifo_u.flushes));
        ready_chk(8'd0, 8'd32, 8'd8, 1'b1, 1'b0);
        ready_chk(8'd0, 8'd128, 8'd8, 1'b1, 1'b1);
        rd(baud_dma_pkg::addr_status, 32'hb, baud_dma_pkg::resp_okay);
        ready_chk(8'd2, 8'd0, 8'd100, 1'b1, 1'b0);
        for (n = 0; rx_timeout !== 1'b1; n++) begin
            if (n > 1000) hang;
            @(negedge aclk);
        end
        cmp_count++;
        if (n < 580 || n > 680) begin
            num_errors++;
            $display("unexpected time-out delay expected %0d seen %0d", 636, n);
        end
        repeat (2) @(negedge aclk);
        chk("rx_dma_ready", 32'h0, 32'(rx_dma_ready));
        print_verdict;
    end
endmodule
